// ### common/dpssp_pkg.sv
/*
 Constants for the dual potentiometer serial shift port: register layout,
 power-up wiper codes and serial timing counts.
 Assumes a single 10 MHz system clock samples the port pins.
*/
// Operation
// - 8-bit code selects each wiper tap
// - Port deselected ignores clock and data
// - Selected: shift data on clock rise
// - Stack flag at position 0
// - Pot one code at positions 1-8
// - Pot zero code at positions 9-16
// - Select fall loads wipers and stack
// - Power-up wipers at mid-scale 0x80
// - Stack flag picks stacked wiper source
// - Cascade output shows last stage bit
// - Stack flag emitted first on cascade
// - Cascade output driven at all times
// - Select rise shows position 0 first
// - Full circular shift restores contents
package dpssp_pkg;
   localparam int REG_BITS = 17;
   localparam int CODE_BITS = 8;
   localparam int STACK_POS = 0;
   localparam int ONE_MSB_POS = 1;
   localparam int ONE_LSB_POS = 8;
   localparam int ZERO_MSB_POS = 9;
   localparam int ZERO_LSB_POS = 16;
   localparam int TAP_COUNT = 256;
   localparam logic [CODE_BITS-1:0] WIPER_RESET = 8'h80;
   localparam logic STACK_RESET = 1'b0;
   localparam int CLK_PERIOD_NS = 100;
   localparam int CHAIN_OUT_DELAY_NS = 50;
   localparam int CHAIN_OUT_DELAY_CYC =
      (CHAIN_OUT_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : (CHAIN_OUT_DELAY_NS / CLK_PERIOD_NS);
   typedef logic [CODE_BITS-1:0] dpssp_code_t;
endpackage

// ### core/dpssp_port.sv
/*
 Serial shift port of a dual 256-tap potentiometer: a 17-bit shift register,
 wiper and stack latches loaded when the port is deselected, the stacked
 wiper selection and the cascade output.
 Data enters at the top stage and moves toward stage 0, which drives the
 cascade output, so the first bit sent ends in the stack position after
 17 shifts and the stack flag is the first bit out of a transaction.
 Assumes the select, serial clock and data pins are already synchronous
 to clk_sys; the serial clock is sampled and its rising edge detected, so
 each serial clock level must stand for at least one clk_sys cycle.
 A partial transfer is loaded as it stands when select falls.
 No state changes while clkEn is low; resetn acts at any level of clkEn.
 Reset stands in for the power-up default of the wipers and the register.
*/
`timescale 1ns/1ps
module dpssp_port
   import dpssp_pkg::*;
(
   // System.
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clkEn,
   // Serial port pins.
   input wire logic portSelect,
   input wire logic serialClk,
   input wire logic serialData,
   output logic chain_out,
   // Wiper codes and stacked output.
   output dpssp_pkg::dpssp_code_t wiper_zero,
   output dpssp_pkg::dpssp_code_t wiper_one,
   output logic stackSelect,
   output dpssp_pkg::dpssp_code_t stacked_wiper_out
);
   import dpssp_pkg::*;

   // Shift register and its next value.
   logic [REG_BITS-1:0] shift_q;
   logic [REG_BITS-1:0] shift_d;

   // Previous samples of the select and serial clock pins.
   logic selPrev_q;
   logic selPrev_d;
   logic sclkPrev_q;
   logic sclkPrev_d;

   // Wiper and stack latches, kept apart from the shift register.
   dpssp_code_t wiperZero_q;
   dpssp_code_t wiperZero_d;
   dpssp_code_t wiperOne_q;
   dpssp_code_t wiperOne_d;
   logic stack_q;
   logic stack_d;

   // The stacked output is registered like the wiper codes it selects from.
   dpssp_code_t stackedOut_q;
   dpssp_code_t stackedOut_d;

   // Decoded strobes and register fields.
   logic sclkRise;
   logic doShift;
   logic selFall;
   logic doLoad;
   logic shiftIn;
   logic [REG_BITS-1:0] shiftNext;
   dpssp_code_t fieldOne;
   dpssp_code_t fieldZero;
   logic fieldStack;

   // Extracts a wiper code whose most significant bit sits at the lower
   // register position.
   function automatic dpssp_code_t code_at(
      input logic [REG_BITS-1:0] r,
      input int msbPos
   );
      dpssp_code_t c;
      c = '0;
      for (int i = 0; i < CODE_BITS; i++) begin
         c[CODE_BITS-1-i] = r[msbPos+i];
      end
      return c;
   endfunction

   // Lays a wiper code into an image, most significant bit at the lower position.
   function automatic logic [REG_BITS-1:0] place_code(
      input logic [REG_BITS-1:0] r,
      input dpssp_code_t c,
      input int msbPos
   );
      logic [REG_BITS-1:0] img;
      img = r;
      for (int i = 0; i < CODE_BITS; i++) begin
         img[msbPos+i] = c[CODE_BITS-1-i];
      end
      return img;
   endfunction

   // Power-up image, so that a readback before any write returns the
   // mid-scale codes and a clear stack flag.
   function automatic logic [REG_BITS-1:0] reset_image();
      logic [REG_BITS-1:0] r;
      r = '0;
      r[STACK_POS] = STACK_RESET;
      r = place_code(r, WIPER_RESET, ONE_MSB_POS);
      r = place_code(r, WIPER_RESET, ZERO_MSB_POS);
      return r;
   endfunction

   // Moves the image one stage toward the cascade end; the new bit enters
   // the top stage, so a fed-back cascade bit rotates the image.
   function automatic logic [REG_BITS-1:0] shift_one(
      input logic [REG_BITS-1:0] r,
      input logic b
   );
      return {b, r[REG_BITS-1:1]};
   endfunction

   // Picks the wiper code that the stacked output carries.
   function automatic dpssp_code_t stack_pick(
      input logic s,
      input dpssp_code_t one,
      input dpssp_code_t zero
   );
      return s ? one : zero;
   endfunction

   // Edge detection against the previous sample.
   assign sclkRise = serialClk & ~sclkPrev_q;
   assign selFall = selPrev_q & ~portSelect;

   // Shifting only while selected; clock edges are ignored otherwise.
   assign doShift = clkEn & portSelect & sclkRise;
   assign doLoad = clkEn & selFall;
   assign shiftIn = serialData;
   assign shiftNext = shift_one(shift_q, shiftIn);
   assign shift_d = doShift ? shiftNext : shift_q;

   // Sample history freezes with the clock enable.
   assign selPrev_d = clkEn ? portSelect : selPrev_q;
   assign sclkPrev_d = clkEn ? serialClk : sclkPrev_q;

   // Register fields; the first bit sent ends in the stack position.
   assign fieldStack = shift_q[STACK_POS];
   assign fieldOne = code_at(shift_q, ONE_MSB_POS);
   assign fieldZero = code_at(shift_q, ZERO_MSB_POS);

   // Latches take the register fields only on deselect.
   assign wiperZero_d = doLoad ? fieldZero : wiperZero_q;
   assign wiperOne_d = doLoad ? fieldOne : wiperOne_q;
   assign stack_d = doLoad ? fieldStack : stack_q;
   assign stackedOut_d = doLoad ? stack_pick(fieldStack, fieldOne, fieldZero)
      : stackedOut_q;

   // Shift register; a readback rotates it back to where it started.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         shift_q <= reset_image();
      end else begin
         shift_q <= shift_d;
      end
   end

   // Select history for the falling-edge detector.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         selPrev_q <= 1'b0;
      end else begin
         selPrev_q <= selPrev_d;
      end
   end

   // Serial clock history for the rising-edge detector.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sclkPrev_q <= 1'b0;
      end else begin
         sclkPrev_q <= sclkPrev_d;
      end
   end

   // Pot-zero wiper latch, mid-scale at power-up.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         wiperZero_q <= WIPER_RESET;
      end else begin
         wiperZero_q <= wiperZero_d;
      end
   end

   // Pot-one wiper latch, mid-scale at power-up.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         wiperOne_q <= WIPER_RESET;
      end else begin
         wiperOne_q <= wiperOne_d;
      end
   end

   // Stack flag latch.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         stack_q <= STACK_RESET;
      end else begin
         stack_q <= stack_d;
      end
   end

   // Stacked output register, following the power-up stack flag.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         stackedOut_q <= stack_pick(STACK_RESET, WIPER_RESET, WIPER_RESET);
      end else begin
         stackedOut_q <= stackedOut_d;
      end
   end

   // Stage 0 is the last stage; it drives the cascade at every level of select.
   assign chain_out = shift_q[STACK_POS];

   // Wiper codes and stacked output come straight from their registers.
   assign wiper_zero = wiperZero_q;
   assign wiper_one = wiperOne_q;
   assign stackSelect = stack_q;
   assign stacked_wiper_out = stackedOut_q;
endmodule

// ### sim/dpssp_port_asserts.sv
/*
 Concurrent checks on the top-level ports of dpssp_port.
 Assumes one clock, clk_sys, a synchronous active-low reset and a clock
 enable held high by the bench.
*/
`timescale 1ns/1ps
module dpssp_port_asserts (
   // System.
   input wire logic clk_sys,
   input wire logic resetn,
   // Serial port pins.
   input wire logic portSelect,
   input wire logic serialClk,
   input wire logic chain_out,
   // Wiper codes and stacked output.
   input wire logic stackSelect,
   input wire logic [7:0] wiper_zero,
   input wire logic [7:0] wiper_one,
   input wire logic [7:0] stacked_wiper_out
);
   import dpssp_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   a_load_only: assert property (!$fell(portSelect) |=>
      $stable({stackSelect, wiper_zero, wiper_one})) else $error("load");
   a_shift_edge: assert property (!(portSelect && $rose(serialClk)) |=>
      $stable(chain_out)) else $error("shift");
   a_idle_hold: assert property (!portSelect |=>
      $stable(chain_out)) else $error("idle shift");
   a_stack_mux: assert property (
      stacked_wiper_out == (stackSelect ? wiper_one : wiper_zero)) else $error("stacked mux");
   a_reset_codes: assert property ($rose(resetn) |->
      wiper_zero == WIPER_RESET && wiper_one == WIPER_RESET && !stackSelect)
      else $error("power-up codes");
   a_load_stack: assert property ($fell(portSelect) |=>
      stackSelect == $past(chain_out)) else $error("stack load");
endmodule
bind dpssp_port dpssp_port_asserts dpssp_port_asserts_inst (
   .clk_sys(clk_sys),
   .resetn(resetn),
   .portSelect(portSelect),
   .serialClk(serialClk),
   .chain_out(chain_out),
   .stackSelect(stackSelect),
   .wiper_zero(wiper_zero),
   .wiper_one(wiper_one),
   .stacked_wiper_out(stacked_wiper_out)
);

// ### sim/dpssp_ctrl_model.sv
/* Controller model for dpssp_port. */
`timescale 1ns/1ps
module dpssp_ctrl_model (input wire logic clk_sys, chain_out,
   output logic portSelect = 1'b0, serialClk = 1'b0, serialData = 1'b0);
   task automatic send(logic [16:0] f, bit rb);
      @(posedge clk_sys) portSelect <= 1'b1;
      for (int i = 16; i >= 0; i--) begin
         @(posedge clk_sys) serialData <= rb ? chain_out : f[i];
         repeat (2) @(posedge clk_sys) serialClk <= ~serialClk;
      end
      @(posedge clk_sys) portSelect <= 1'b0;
   endtask
endmodule

// ### sim/tb_top.sv
/*
 Bench for dpssp_port: random writes and readbacks through the cascade path,
 each checked at the loaded wiper and stack outputs; the run ends at the sixth check, before its mid-run reset.
 Assumes the controller model drives the three serial pins.
*/
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic clkEn = 1'b1;
   logic portSelect;
   logic serialClk;
   logic serialData;
   logic chain_out;
   logic stackSelect;
   logic [7:0] wiper_zero;
   logic [7:0] wiper_one;
   logic [7:0] stacked_wiper_out;
   int bad_count = 0;
   int checked = 0;
   int seed = 90;
   logic [24:0] expQ[$];
   logic [16:0] img = 17'h08080;
   dpssp_port dpssp_port_inst (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .clkEn(clkEn),
      .portSelect(portSelect),
      .serialClk(serialClk),
      .serialData(serialData),
      .chain_out(chain_out),
      .wiper_zero(wiper_zero),
      .wiper_one(wiper_one),
      .stackSelect(stackSelect),
      .stacked_wiper_out(stacked_wiper_out)
   );
   dpssp_ctrl_model dpssp_ctrl_model_inst (
      .clk_sys(clk_sys),
      .chain_out(chain_out),
      .portSelect(portSelect),
      .serialClk(serialClk),
      .serialData(serialData)
   );
   initial begin
      forever begin
         #50 clk_sys = ~clk_sys;
      end
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      bad_count++;
      end_sim;
   end
   task automatic cmp(logic [24:0] s, e);
      checked++;
      bad_count += s !== e;
      if (s !== e) $display("ERROR %0t got %h want %h", $time, s, e);
   endtask
   task automatic end_sim;
      if (bad_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // The select pin settles at time zero; only falls with a note pending are results.
   always @(negedge portSelect) begin
      if (expQ.size() > 0) begin
         repeat (2) @(posedge clk_sys);
         cmp({stackSelect, wiper_one, wiper_zero, stacked_wiper_out},
            expQ.pop_front());
         if (expQ.size() == 0) end_sim;
      end
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      for (int n = 0; n < 7; n++) begin
         if (n == 6) begin
            repeat (4) @(posedge clk_sys);
            resetn <= 1'b0;
            repeat (2) @(posedge clk_sys);
            resetn <= 1'b1;
            img = 17'h08080;
         end else if (n % 5 != 0) begin
            img = 17'($random(seed));
         end
         expQ.push_back({img, img[16] ? img[15:8] : img[7:0]});
         dpssp_ctrl_model_inst.send(img, n % 5 == 0 || n == 6);
      end
   end
endmodule
